// >>> logic/swh_host.sv
// host end: issues start, times the sensor's pulses and checks the frame
`timescale 1ns/10ps
module swh_host #(
    parameter int SETTLE_US = swh_pkg::SETTLE_US_DEF,  // wait after reset
    parameter int GAP_US    = swh_pkg::GAP_US_DEF,     // wait between reads
    parameter int US_DIV    = swh_pkg::US_CYC          // clock cycles per microsecond
) (
    input  wire logic                       mclk,       // 250 MHz clock
    input  wire logic                       sys_rst,    // async reset, active high
    swh_link_if.host                        link,       // shared data line
    input  wire logic                       readReq,    // request a read
    input  wire logic                       readFresh,  // read twice, report second
    output logic                            ready,      // read request accepted now
    output logic [swh_pkg::WORD_W-1:0]      humOut,     // humidity, tenths of percent
    output logic                            tempNegOut, // temperature below zero
    output logic [swh_pkg::MAG_W-1:0]       tempMagOut, // temperature magnitude, tenths
    output logic                            dataValid,  // pulse: new result out
    output logic                            errStb,     // pulse: frame dropped
    output logic                            errCksum    // last error: 1 checksum, 0 timeout
);
    import swh_pkg::*;

    if (SETTLE_US < 1 || SETTLE_US >= 2 ** CNT_W || GAP_US < 1 || GAP_US >= 2 ** CNT_W
        || US_DIV < 2) begin : badParam
        $error("swh_host: SETTLE_US, GAP_US or US_DIV out of range");
    end

    typedef enum {
        H_SETTLE,
        H_IDLE,
        H_START,
        H_WRESP,
        H_RLO,
        H_RHI,
        H_BLO,
        H_BHI,
        H_END,
        H_GAP
    } swh_host_st_type;

    swh_host_st_type st_q;
    swh_host_st_type st_d;

    logic                  sdaM_q;
    logic                  sdaS_q;
    logic [FRAME_BITS-1:0] rx_q;
    swh_bit_type           bitCnt_q;
    logic                  fresh_q;
    logic                  again_q;
    swh_cnt_type           usCnt;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sdaM_q <= 1'h1;
            sdaS_q <= 1'h1;
        end else begin
            sdaM_q <= link.sda;
            sdaS_q <= sdaM_q;
        end
    end

    wire lineLow = ~sdaS_q;

    swh_us_timer #(
        .DIV (US_DIV),
        .CW  (CNT_W)
    ) uTimer (
        .clk   (mclk),
        .rst   (sys_rst),
        .clr   (st_d != st_q),
        .count (usCnt)
    );

    wire              edgeLate = (usCnt >= EDGE_TO_US);
    wire              lastBit  = (bitCnt_q == swh_bit_type'(FRAME_BITS - 1));
    wire [BYTE_W-1:0] sum8     = rx_q[39:32] + rx_q[31:24]
                               + rx_q[23:16] + rx_q[15:8];
    wire              ckOk     = (sum8 == rx_q[7:0]);
    wire              takeReq  = (st_q == H_IDLE) && readReq;
    wire              bitTake  = (st_q == H_BHI) && lineLow;
    // a late end-low counts as a timeout even though the bits are all in
    wire              finish   = (st_q == H_END) && !lineLow;
    wire              toErr    = (st_d == H_GAP) && (st_q != H_GAP) && !finish;
    wire              ckErr    = finish && !ckOk;
    wire              goodEnd  = finish && ckOk;
    wire              bitVal   = (usCnt >= BIT_THRESH_US);

    always_comb begin
        st_d = st_q;
        case (st_q)
            H_SETTLE: begin
                if (usCnt >= swh_cnt_type'(SETTLE_US)) begin
                    st_d = H_IDLE;
                end
            end
            H_IDLE: begin
                if (readReq) begin
                    st_d = H_START;
                end
            end
            H_START: begin
                if (usCnt >= START_HOST_US) begin
                    st_d = H_WRESP;
                end
            end
            H_WRESP: begin
                if (lineLow && usCnt >= RISE_GUARD_US) begin
                    st_d = H_RLO;
                end else if (usCnt >= TGO_MAX_US) begin
                    st_d = H_GAP;
                end
            end
            H_RLO: begin
                st_d = !lineLow ? H_RHI : (edgeLate ? H_GAP : H_RLO);
            end
            H_RHI: begin
                st_d = lineLow ? H_BLO : (edgeLate ? H_GAP : H_RHI);
            end
            H_BLO: begin
                st_d = !lineLow ? H_BHI : (edgeLate ? H_GAP : H_BLO);
            end
            H_BHI: begin
                if (lineLow) begin
                    st_d = lastBit ? H_END : H_BLO;
                end else if (edgeLate) begin
                    st_d = H_GAP;
                end
            end
            H_END: begin
                if (!lineLow || edgeLate) begin
                    st_d = H_GAP;
                end
            end
            H_GAP: begin
                if (usCnt >= swh_cnt_type'(GAP_US)) begin
                    st_d = again_q ? H_START : H_IDLE;
                end
            end
            default: begin
                st_d = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q     <= H_SETTLE;
            rx_q     <= '0;
            bitCnt_q <= '0;
        end else begin
            st_q <= st_d;
            if (st_q == H_START) begin
                bitCnt_q <= '0;
            end else if (bitTake) begin
                rx_q     <= {rx_q[FRAME_BITS-2:0], bitVal};
                bitCnt_q <= bitCnt_q + 1'h1;
            end
        end
    end

    // a fresh read throws away the first, stale frame and reads again
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            fresh_q    <= 1'h0;
            again_q    <= 1'h0;
            humOut     <= '0;
            tempNegOut <= 1'h0;
            tempMagOut <= '0;
            dataValid  <= 1'h0;
            errStb     <= 1'h0;
            errCksum   <= 1'h0;
        end else begin
            dataValid <= goodEnd && !fresh_q;
            errStb    <= toErr || ckErr;
            if (takeReq) begin
                fresh_q <= readFresh;
            end else if (finish || toErr) begin
                fresh_q <= 1'h0;
            end
            if (goodEnd && fresh_q) begin
                again_q <= 1'h1;
            end else if (st_q == H_GAP && st_d != H_GAP) begin
                again_q <= 1'h0;
            end
            if (toErr || ckErr) begin
                errCksum <= ckErr;
            end
            if (goodEnd && !fresh_q) begin
                humOut     <= rx_q[39:24];
                tempNegOut <= rx_q[23];
                tempMagOut <= rx_q[22:8];
            end
        end
    end

    assign ready        = (st_q == H_IDLE);
    assign link.hostOut = 1'h0;
    assign link.hostOeN = (st_q != H_START);
endmodule // swh_host

// >>> inc/swh_pkg.sv
// shared constants and types for the single-wire humidity/temperature link
package swh_pkg;
    localparam int CLK_HZ     = 250_000_000;
    localparam int US_CYC     = CLK_HZ / 1_000_000;   // clock cycles per microsecond
    localparam int CNT_W      = 22;
    localparam int WORD_W     = 16;
    localparam int MAG_W      = 15;
    localparam int BYTE_W     = 8;
    localparam int FRAME_BITS = 40;
    localparam int BIT_W      = 6;

    typedef logic [CNT_W-1:0] swh_cnt_type;
    typedef logic [BIT_W-1:0] swh_bit_type;

    // pulse widths in microseconds
    localparam swh_cnt_type START_HOST_US = swh_cnt_type'(1000);
    localparam swh_cnt_type START_DET_US  = swh_cnt_type'(800);
    localparam swh_cnt_type REL_WAIT_US   = swh_cnt_type'(30);
    localparam swh_cnt_type RESP_LOW_US   = swh_cnt_type'(80);
    localparam swh_cnt_type RESP_HIGH_US  = swh_cnt_type'(80);
    localparam swh_cnt_type BIT_LOW_US    = swh_cnt_type'(50);
    localparam swh_cnt_type BIT0_HIGH_US  = swh_cnt_type'(26);
    localparam swh_cnt_type BIT1_HIGH_US  = swh_cnt_type'(70);
    localparam swh_cnt_type END_LOW_US    = swh_cnt_type'(50);
    localparam swh_cnt_type BIT_THRESH_US = swh_cnt_type'(48);
    localparam swh_cnt_type TGO_MAX_US    = swh_cnt_type'(200);
    localparam swh_cnt_type EDGE_TO_US    = swh_cnt_type'(100);
    localparam swh_cnt_type RISE_GUARD_US = swh_cnt_type'(2);

    // long times, defaults of top-level parameters
    localparam int START_MAX_US_DEF = 20_000;
    localparam int SETTLE_US_DEF    = 2_000_000;
    localparam int GAP_US_DEF       = 2_000_000;
endpackage

// >>> inc/swh_link_if.sv
// shared open-drain data line between host end and sensor end
`timescale 1ns/10ps
interface swh_link_if;
    logic hostOut;   // host pin output value
    logic hostOeN;   // host output enable, low while driving
    logic sensOut;   // sensor pin output value
    logic sensOeN;   // sensor output enable, low while driving
    logic sda;       // resolved line level, pulled up when nobody drives low

    assign sda = ~((~hostOeN & ~hostOut) | (~sensOeN & ~sensOut));

    modport host   (output hostOut, output hostOeN, input sda);
    modport sensor (output sensOut, output sensOeN, input sda);
endinterface

// >>> logic/swh_us_timer.sv
// microsecond timer: clock divider plus saturating count since last clear
`timescale 1ns/10ps
module swh_us_timer #(
    parameter int DIV = 250,   // clock cycles per microsecond
    parameter int CW  = 22     // count width
) (
    input  wire logic          clk,    // system clock
    input  wire logic          rst,    // async reset, high
    input  wire logic          clr,    // restart from zero
    output logic [CW-1:0]      count   // whole microseconds since clear
);
    localparam int DW = $clog2(DIV);

    if (DIV < 2 || CW < 2) begin : badParam
        $error("swh_us_timer: DIV and CW must be at least 2");
    end

    logic [DW-1:0] div_q;
    wire           tick = (div_q == DW'(DIV - 1));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_q <= '0;
            count <= '0;
        end else if (clr) begin
            div_q <= '0;
            count <= '0;
        end else begin
            div_q <= tick ? '0 : div_q + 1'h1;
            // saturate so a stuck line never wraps back into a short pulse
            if (tick && count != '1) begin
                count <= count + 1'h1;
            end
        end
    end
endmodule // swh_us_timer

// >>> logic/swh_sensor.sv
// sensor end: answers a host start with response and 40-bit measurement frame
`timescale 1ns/10ps
// Behaviour
// - both ends only pull low, else release
// - sensor speaks only after a valid start
// - broken start sequence gets no answer
// - host holds start low at least 1 ms
// - response is 80 us low, 80 us high
// - then exactly 40 bits, MSB first
// - humidity is 16-bit unsigned, tenths of percent
// - temperature is sign bit plus 15-bit magnitude
// - checksum byte is sum of four bytes
// - host leaves 2 s between reads
// - host waits over 2 s after power-up
// - each read returns the previous measurement
// - sensor pin switches between input and output
// - zero bit is 50 us low, 26 us high
// - one bit is 50 us low, 70 us high
// - after last bit 50 us low, then release
// - byte order humidity, temperature, then checksum
module swh_sensor #(
    parameter int US_DIV       = swh_pkg::US_CYC,           // clock cycles per microsecond
    parameter int START_MAX_US = swh_pkg::START_MAX_US_DEF  // longest start low accepted
) (
    input  wire logic                       mclk,       // 250 MHz clock
    input  wire logic                       sys_rst,    // async reset, active high
    swh_link_if.sensor                      link,       // shared data line
    input  wire logic [swh_pkg::WORD_W-1:0] humIn,      // humidity, tenths of percent
    input  wire logic                       tempNegIn,  // temperature below zero
    input  wire logic [swh_pkg::MAG_W-1:0]  tempMagIn,  // temperature magnitude, tenths
    output logic                            measTake,   // pulse: inputs sampled
    output logic                            busy        // transaction in progress
);
    import swh_pkg::*;

    // below two cycles a microsecond the release guard no longer covers the synchroniser
    if (START_MAX_US <= 800 || START_MAX_US >= 2 ** CNT_W || US_DIV < 2) begin : badParam
        $error("swh_sensor: START_MAX_US or US_DIV out of range");
    end

    typedef enum {
        S_IDLE,
        S_START,
        S_WAITHI,
        S_GAP,
        S_RLO,
        S_RHI,
        S_BLO,
        S_BHI,
        S_ELO
    } swh_sens_st_type;

    swh_sens_st_type st_q;
    swh_sens_st_type st_d;

    logic                    sdaM_q;
    logic                    sdaS_q;
    logic [FRAME_BITS-1:0]   frame_q;
    swh_bit_type             bitCnt_q;
    logic [WORD_W-1:0]       measHum_q;
    logic [WORD_W-1:0]       measTmp_q;
    logic                    capPend_q;
    swh_cnt_type             usCnt;

    // line sampled through two flops, only the second is looked at
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sdaM_q <= 1'h1;
            sdaS_q <= 1'h1;
        end else begin
            sdaM_q <= link.sda;
            sdaS_q <= sdaM_q;
        end
    end

    wire lineLow = ~sdaS_q;
    wire stChg   = (st_d != st_q);

    swh_us_timer #(
        .DIV (US_DIV),
        .CW  (CNT_W)
    ) uTimer (
        .clk   (mclk),
        .rst   (sys_rst),
        .clr   (stChg),
        .count (usCnt)
    );

    wire [BYTE_W-1:0] cksum = measHum_q[15:8] + measHum_q[7:0]
                            + measTmp_q[15:8] + measTmp_q[7:0];
    wire [WORD_W-1:0] tmpWord   = {tempNegIn, tempMagIn};
    wire swh_cnt_type highUs    = frame_q[FRAME_BITS-1] ? BIT1_HIGH_US
                                                        : BIT0_HIGH_US;
    wire              lastBit   = (bitCnt_q == swh_bit_type'(FRAME_BITS - 1));
    // our own release takes a few cycles to show through the synchroniser
    wire              hostClash = lineLow && usCnt >= RISE_GUARD_US;
    wire              drvLow    = (st_q == S_RLO) || (st_q == S_BLO) || (st_q == S_ELO);
    wire              loadFrame = (st_q == S_GAP) && (st_d == S_RLO);
    wire              shiftBit  = (st_q == S_BHI) && (st_d == S_BLO);
    wire              frameDone = (st_q == S_ELO) && (st_d != S_ELO);
    wire              capNow    = capPend_q && (st_q == S_IDLE);

    always_comb begin
        st_d = st_q;
        case (st_q)
            S_IDLE: begin
                if (lineLow) begin
                    st_d = S_START;
                end
            end
            S_START: begin
                if (!lineLow) begin
                    st_d = (usCnt >= START_DET_US) ? S_GAP : S_IDLE;
                end else if (usCnt >= swh_cnt_type'(START_MAX_US)) begin
                    st_d = S_WAITHI;
                end
            end
            S_WAITHI: begin
                if (!lineLow) begin
                    st_d = S_IDLE;
                end
            end
            S_GAP: begin
                if (lineLow) begin
                    st_d = S_WAITHI;
                end else if (usCnt >= REL_WAIT_US) begin
                    st_d = S_RLO;
                end
            end
            S_RLO: begin
                if (usCnt >= RESP_LOW_US) begin
                    st_d = S_RHI;
                end
            end
            S_RHI: begin
                if (hostClash) begin
                    st_d = S_WAITHI;
                end else if (usCnt >= RESP_HIGH_US) begin
                    st_d = S_BLO;
                end
            end
            S_BLO: begin
                if (usCnt >= BIT_LOW_US) begin
                    st_d = S_BHI;
                end
            end
            S_BHI: begin
                if (hostClash) begin
                    st_d = S_WAITHI;
                end else if (usCnt >= highUs) begin
                    st_d = lastBit ? S_ELO : S_BLO;
                end
            end
            S_ELO: begin
                // back through the wait-for-high state so our own tail is
                // never mistaken for a new start
                if (usCnt >= END_LOW_US) begin
                    st_d = S_WAITHI;
                end
            end
            default: begin
                st_d = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= S_IDLE;
            busy <= 1'h0;
        end else begin
            st_q <= st_d;
            busy <= (st_d != S_IDLE);
        end
    end

    // frame shift register, most significant bit on the wire first
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            frame_q  <= '0;
            bitCnt_q <= '0;
        end else if (loadFrame) begin
            frame_q  <= {measHum_q, measTmp_q, cksum};
            bitCnt_q <= '0;
        end else if (shiftBit) begin
            frame_q  <= {frame_q[FRAME_BITS-2:0], 1'h0};
            bitCnt_q <= bitCnt_q + 1'h1;
        end
    end

    // a new sample is taken once after reset and after every frame that reaches its end low, so
    // each read carries the value captured at the end of the last frame that did
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            measHum_q <= '0;
            measTmp_q <= '0;
            capPend_q <= 1'h1;
            measTake  <= 1'h0;
        end else begin
            capPend_q <= frameDone | (capPend_q & ~capNow);
            measTake  <= capNow;
            if (capNow) begin
                measHum_q <= humIn;
                measTmp_q <= tmpWord;
            end
        end
    end

    // pin only ever pulls low; released it is an input again
    assign link.sensOut = 1'h0;
    assign link.sensOeN = ~drvLow;
endmodule // swh_sensor

// >>> bench/swh_link_props.sv
// checker for the shared line: drive rules, pulse widths and counts
`timescale 1ns/10ps
module swh_link_props
    import swh_pkg::*;
#(
    parameter int SETTLE_US = 10,  // host wait after reset, as in the bench
    parameter int GAP_US    = 10,  // host wait between reads, as in the bench
    parameter int US_DIV    = 4    // cycles per microsecond, as in the bench
) (
    input wire logic mclk,     // system clock
    input wire logic sys_rst,  // async reset, high
    input wire logic hostOut,  // host pin value
    input wire logic hostOeN,  // host drives when low
    input wire logic sensOut,  // sensor pin value
    input wire logic sensOeN,  // sensor drives when low
    input wire logic sda       // resolved line level
);
    localparam int US   = US_DIV;
    localparam int SAT  = 1 << 28;
    // small margin: the host counts its wait from its own state change
    localparam int IDLE = (SETTLE_US < GAP_US ? SETTLE_US : GAP_US) * US - 4;
    int sensLo_q, sensHi_q, hostLo_q, lastStart_q, idle_q, pulses_q;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sensLo_q    <= 0;
            sensHi_q    <= 0;
            hostLo_q    <= 0;
            lastStart_q <= 0;
            idle_q      <= 0;
            pulses_q    <= 0;
        end else begin
            sensLo_q    <= sensOeN ? 0 : sensLo_q + 1;
            sensHi_q    <= !sensOeN ? 0 : (sensHi_q < SAT ? sensHi_q + 1 : SAT);
            hostLo_q    <= hostOeN ? 0 : hostLo_q + 1;
            lastStart_q <= (hostOeN && hostLo_q != 0) ? hostLo_q : (sensOeN ? lastStart_q : 0);
            idle_q      <= sda ? (idle_q < SAT ? idle_q + 1 : SAT) : 0;
            pulses_q    <= (!hostOeN || sensHi_q > 200 * US) ? 0 :
                           (sensOeN && sensLo_q != 0) ? pulses_q + 1 : pulses_q;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    sequence s_resp_fall;
        $fell(sensOeN) && sensHi_q > 150 * US;
    endsequence
    sequence s_last_rise;
        $rose(sensOeN) && pulses_q == 41;
    endsequence

    property p_host_low;
        !hostOeN |-> !hostOut;
    endproperty
    property p_sens_low;
        !sensOeN |-> !sensOut;
    endproperty
    property p_no_clash;
        !hostOeN |-> sensOeN;
    endproperty
    property p_resp_start;
        s_resp_fall |-> lastStart_q >= 800 * US;
    endproperty
    property p_low_len;
        $rose(sensOeN) |-> sensLo_q inside {[45 * US:55 * US], [75 * US:85 * US]};
    endproperty
    property p_high_len;
        $fell(sensOeN) && sensHi_q < 150 * US |->
            sensHi_q inside {[22 * US:30 * US], [68 * US:85 * US]};
    endproperty
    property p_bit_count;
        sensHi_q == 200 * US && pulses_q != 0 |-> pulses_q == 42;
    endproperty
    property p_end_idle;
        s_last_rise |-> sensOeN [*8];
    endproperty
    property p_host_start;
        $rose(hostOeN) |-> hostLo_q >= 1000 * US;
    endproperty
    property p_gap;
        $fell(hostOeN) |-> idle_q >= IDLE;
    endproperty

    a_host_low: assert property (p_host_low)
        else $error("host drives the line high");
    a_sens_low: assert property (p_sens_low)
        else $error("sensor drives the line high");
    a_no_clash: assert property (p_no_clash)
        else $error("sensor drives while host holds the line");
    a_resp_start: assert property (p_resp_start)
        else $error("sensor answered without a valid start");
    a_low_len: assert property (p_low_len)
        else $error("sensor low pulse width off");
    a_high_len: assert property (p_high_len)
        else $error("sensor high phase width off");
    a_bit_count: assert property (p_bit_count)
        else $error("wrong pulse count in frame");
    a_end_idle: assert property (p_end_idle)
        else $error("line not released after end low");
    a_host_start: assert property (p_host_start)
        else $error("start low too short");
    a_gap: assert property (p_gap)
        else $error("start issued too soon");
endmodule // swh_link_props

// >>> bench/single_wire_humidity_temp_readout_tb.sv
// self-checking bench: host and sensor ends joined on one line
`timescale 1ns/10ps
module single_wire_humidity_temp_readout_tb;
    import swh_pkg::*;
    localparam int LIM     = 60_000;
    // four cycles a microsecond keeps three frames under 80k cycles; checker default matches
    localparam int SIM_DIV = 4;
    localparam int SIM_US  = 10;
    logic        mclk, sys_rst, readReq, readFresh, tempNeg, measTake, busy, busy2, ready;
    logic        dataValid, errStb, errCksum, tempNegOut;
    logic        lastSda = 1'b1;
    logic        quiet   = 1'b1;
    logic [15:0] hum, humOut;
    logic [14:0] mag, tempMagOut;
    logic [31:0] seed    = 32'h95C021A2;
    logic [31:0] samples[$];
    int          runs[$];
    int          runLen  = 0;
    int          dvCount = 0;
    int          bad_count = 0;
    int          checks_done = 0;

    swh_link_if link();
    swh_link_if link2();

    swh_sensor #(.US_DIV(SIM_DIV)) u_swh_sensor (.mclk(mclk), .sys_rst(sys_rst),
        .link(link), .humIn(hum), .tempNegIn(tempNeg), .tempMagIn(mag),
        .measTake(measTake), .busy(busy));
    swh_sensor #(.US_DIV(SIM_DIV)) u_swh_sensor_b (.mclk(mclk), .sys_rst(sys_rst),
        .link(link2), .humIn(hum), .tempNegIn(tempNeg), .tempMagIn(mag),
        .measTake(), .busy(busy2));
    swh_host #(.SETTLE_US(SIM_US), .GAP_US(SIM_US), .US_DIV(SIM_DIV))
        u_swh_host (.mclk(mclk), .sys_rst(sys_rst),
        .link(link), .readReq(readReq), .readFresh(readFresh), .ready(ready),
        .humOut(humOut), .tempNegOut(tempNegOut), .tempMagOut(tempMagOut),
        .dataValid(dataValid), .errStb(errStb), .errCksum(errCksum));
    swh_link_props u_swh_link_props (.mclk(mclk),
        .sys_rst(sys_rst), .hostOut(link.hostOut), .hostOeN(link.hostOeN),
        .sensOut(link.sensOut), .sensOeN(link.sensOeN), .sda(link.sda));

    function automatic logic [31:0] xs(logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    function automatic logic [39:0] frameOf(logic [31:0] smp);
        logic [7:0] ck;
        ck = smp[31:24] + smp[23:16] + smp[15:8] + smp[7:0];
        return {smp, ck};
    endfunction

    function automatic logic inW(int v, int lo, int hi);
        return v >= lo * SIM_DIV && v <= hi * SIM_DIV;
    endfunction

    task automatic chk(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask

    task automatic results();
        $display("checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // one read; the last frame on the wire is decoded from its run lengths
    task automatic readOnce(input logic fresh, input int idx);
        logic [39:0] exp, wb;
        int n, b, lo, hi;
        for (n = 0; n < LIM && ready !== 1'b1; n++) @(posedge mclk);
        runs.delete();
        readReq   <= 1'b1;
        readFresh <= fresh;
        @(posedge mclk);
        readReq <= 1'b0;
        for (n = 0; n < LIM && dataValid !== 1'b1 && errStb !== 1'b1; n++) @(posedge mclk);
        chk(dataValid === 1'b1 && errStb === 1'b0 && errCksum === 1'b0, "no good result");
        exp = frameOf(samples[idx]);
        chk({humOut, tempNegOut, tempMagOut} === exp[39:8], "result words");
        chk(runs.size() >= 86, "too few line edges");
        if (runs.size() < 86) return;
        b = runs.size() - 86;
        chk(inW(runs[b + 1], 1000, 1010), "start low width");
        chk(inW(runs[b + 3], 75, 85) && inW(runs[b + 4], 75, 85), "response widths");
        for (n = 0; n < 40; n++) begin
            lo = runs[b + 5 + 2 * n];
            hi = runs[b + 6 + 2 * n];
            chk(inW(lo, 48, 55) && (inW(hi, 22, 30) || inW(hi, 68, 75)), "bit widths");
            wb[39 - n] = hi > 48 * SIM_DIV;
        end
        chk(wb === exp, "frame bits on the line");
        chk(inW(runs[b + 85], 45, 55), "end low width");
    endtask

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // new values go in only after the sensor has taken a sample
    always @(posedge mclk) begin
        if (measTake === 1'b1) begin
            samples.push_back({hum, tempNeg, mag});
            seed = xs(seed);
            hum     <= seed[15:0] % 16'h03E8;
            tempNeg <= seed[16];
            mag     <= seed[31:17] % 15'h0320;
        end
    end

    always @(posedge mclk) begin
        if (link.sda !== lastSda) begin
            runs.push_back(runLen);
            runLen = 0;
        end
        runLen++;
        lastSda = link.sda;
        if (dataValid === 1'b1) dvCount++;
        if (sys_rst === 1'b0 && link2.sensOeN !== 1'b1) quiet = 1'b0;
    end

    initial begin
        repeat (95_000) @(posedge mclk);
        bad_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        results();
    end

    initial begin
        sys_rst       = 1'b1;
        readReq       = 1'b0;
        readFresh     = 1'b0;
        hum           = 16'h03E7;  // corner: the byte sum carries past bit 7
        tempNeg       = 1'b1;
        mag           = 15'h7FFF;
        link2.hostOut = 1'b0;
        link2.hostOeN = 1'b1;
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge mclk);
        chk(ready === 1'b0 && link.sda === 1'b1, "state after reset");
        readOnce(1'b0, 0);
        readOnce(1'b1, 2);
        @(posedge mclk);
        chk(dvCount == 2, "result pulse count");
        link2.hostOeN <= 1'b0;
        repeat (500 * SIM_DIV) @(posedge mclk);
        link2.hostOeN <= 1'b1;
        repeat (300 * SIM_DIV) @(posedge mclk);
        chk(quiet === 1'b1 && busy2 === 1'b0, "answer to a short start");
        results();
    end
endmodule // single_wire_humidity_temp_readout_tb
